// File: rtl/qec_capture.sv
// Purpose: Encoder capture: interval base, position and command counters, Hall angle
// Assumes: Avalon-MM slave, one wait cycle per access; pins async to clk_i
// Notes:   Speed delta is counts per interval cycle, which CTRL ends on the speed or position match; software divides by that cycle
module qec_capture
  import qec_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
)
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              encoder_phase_a_in_i,
  input  wire logic              encoder_phase_b_in_i,
  input  wire logic              ext_clock_a_in_i,
  input  wire logic              ext_clock_b_in_i,
  input  wire logic              index_pulse_irq_in_i,
  input  wire logic              hall_u_in_i,
  input  wire logic              hall_v_in_i,
  input  wire logic              hall_w_in_i,
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic      [CNT_W-1:0]  position_count_value_o,
  output logic                   sensor_fault_o
);

  logic [CNT_W-1:0] interval_counter_r;
  logic [CNT_W-1:0] interval_counter_nxt;
  logic [CNT_W-1:0] speed_period_compare_r;
  logic [CNT_W-1:0] position_period_compare_r;
  logic [CNT_W-1:0] edge_width_capture_r;
  logic [CNT_W-1:0] edge_width_buffer_r;
  logic [CNT_W-1:0] encoder_position_counter;
  logic [CNT_W-1:0] encoder_speed_capture_r;
  logic [CNT_W-1:0] encoder_position_capture_r;
  logic [CNT_W-1:0] command_pulse_counter;
  logic [CNT_W-1:0] command_speed_capture_r;
  logic [CNT_W-1:0] command_position_capture_r;
  logic [CNT_W-1:0] speed_delta_r;
  logic             clr_on_pos_r;
  logic             spd_match;
  logic             pos_match;
  logic             clr_match;
  logic             enc_edge;
  logic             enc_dir;
  logic             cmd_edge;
  logic             cmd_dir;
  logic             idx_meta_r;
  logic             idx_sync_r;
  logic             idx_prev_r;
  logic             idx_rise;
  logic             index_seen_r;
  logic [2:0]       hall_sector;
  logic             hall_fault;
  logic             hall_track;
  logic [ANG_W-1:0] hall_angle;
  logic             ack_r;
  logic             req;
  logic             wr_go;
  logic [31:0]      rd_mux;
  logic [31:0]      status_word;

  function automatic logic [31:0] zext(input logic [CNT_W-1:0] v);
    zext = {{(32-CNT_W){1'b0}}, v};
  endfunction : zext

  // Byte lanes beyond CNT_W are dropped on the floor
  function automatic logic [CNT_W-1:0] merge_be(input logic [CNT_W-1:0] old,
                                                input logic [31:0]      wd,
                                                input logic [3:0]       be);
    logic [31:0] tmp;
    tmp = zext(old);
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        tmp[i*8 +: 8] = wd[i*8 +: 8];
    end
    merge_be = tmp[CNT_W-1:0];
  endfunction : merge_be

  // Encoder and command pulse counters
  qec_quad #(
    .W (CNT_W)
  ) u_enc_quad (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .phase_a_i (encoder_phase_a_in_i),
    .phase_b_i (encoder_phase_b_in_i),
    .zero_i    (idx_rise),
    .count_o   (encoder_position_counter),
    .edge_o    (enc_edge),
    .dir_o     (enc_dir)
  );

  qec_quad #(
    .W (CNT_W)
  ) u_cmd_quad (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .phase_a_i (ext_clock_a_in_i),
    .phase_b_i (ext_clock_b_in_i),
    .zero_i    (1'b0),
    .count_o   (command_pulse_counter),
    .edge_o    (cmd_edge),
    .dir_o     (cmd_dir)
  );

  qec_hall u_hall (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .hall_u_i  (hall_u_in_i),
    .hall_v_i  (hall_v_in_i),
    .hall_w_i  (hall_w_in_i),
    .sector_o  (hall_sector),
    .fault_o   (hall_fault),
    .track_o   (hall_track),
    .angle_o   (hall_angle)
  );

  // Index pulse synchroniser and rising-edge detect
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      idx_meta_r <= 1'b0;
      idx_sync_r <= 1'b0;
      idx_prev_r <= 1'b0;
    end
    else
    begin
      idx_meta_r <= index_pulse_irq_in_i;
      idx_sync_r <= idx_meta_r;
      idx_prev_r <= idx_sync_r;
    end
  end

  assign idx_rise = idx_sync_r & ~idx_prev_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      index_seen_r <= 1'b0;
    else if (idx_rise)
      index_seen_r <= 1'b1;
  end

  // Interval time base and the two loop-period matches
  assign spd_match = (interval_counter_r == speed_period_compare_r);
  assign pos_match = (interval_counter_r == position_period_compare_r);
  assign clr_match = clr_on_pos_r ? pos_match : spd_match;

  always_comb
  begin
    if (clr_match)
      interval_counter_nxt = '0;
    else
      interval_counter_nxt = interval_counter_r + CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      interval_counter_r <= '0;
    else
      interval_counter_r <= interval_counter_nxt;
  end

  // Edge width capture and buffer, shifted on every encoder edge
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      edge_width_capture_r <= '0;
      edge_width_buffer_r  <= '0;
    end
    else if (enc_edge)
    begin
      edge_width_capture_r <= interval_counter_r;
      edge_width_buffer_r  <= edge_width_capture_r;
    end
  end

  // Speed-period captures and speed delta
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      encoder_speed_capture_r <= '0;
      command_speed_capture_r <= '0;
      speed_delta_r           <= '0;
    end
    else if (spd_match)
    begin
      encoder_speed_capture_r <= encoder_position_counter;
      command_speed_capture_r <= command_pulse_counter;
      speed_delta_r <= encoder_position_counter - encoder_speed_capture_r;
    end
  end

  // Position-period captures
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      encoder_position_capture_r <= '0;
      command_position_capture_r <= '0;
    end
    else if (pos_match)
    begin
      encoder_position_capture_r <= encoder_position_counter;
      command_position_capture_r <= command_pulse_counter;
    end
  end

  // Avalon-MM: one wait cycle, read data latched before waitrequest drops
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_go             = avs_write_i & ack_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      clr_on_pos_r              <= CTRL_CLR_SEL_RST;
      speed_period_compare_r    <= CNT_W'(SPD_CMP_RST);
      position_period_compare_r <= CNT_W'(POS_CMP_RST);
    end
    else if (wr_go)
    begin
      unique case (avs_address_i & 8'hfc)
        ADDR_CTRL:
        begin
          if (avs_byteenable_i[0])
            clr_on_pos_r <= avs_writedata_i[CTRL_CLR_SEL_BIT];
        end
        ADDR_SPD_CMP:
          speed_period_compare_r <= merge_be(speed_period_compare_r,
                                             avs_writedata_i, avs_byteenable_i);
        ADDR_POS_CMP:
          position_period_compare_r <= merge_be(position_period_compare_r,
                                                avs_writedata_i, avs_byteenable_i);
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    status_word = 32'h0;
    status_word[STAT_SECTOR_LSB +: 3] = hall_sector;
    status_word[STAT_FAULT_BIT]       = hall_fault;
    status_word[STAT_TRACK_BIT]       = hall_track;
    status_word[STAT_INDEX_BIT]       = index_seen_r;
    status_word[STAT_ENC_DIR_BIT]     = enc_dir;
    status_word[STAT_CMD_DIR_BIT]     = cmd_dir;
  end

  always_comb
  begin
    unique case (avs_address_i & 8'hfc)
      ADDR_CTRL:        rd_mux = {31'h0, clr_on_pos_r};
      ADDR_SPD_CMP:     rd_mux = zext(speed_period_compare_r);
      ADDR_POS_CMP:     rd_mux = zext(position_period_compare_r);
      ADDR_INTERVAL:    rd_mux = zext(interval_counter_r);
      ADDR_EDGE_CAP:    rd_mux = zext(edge_width_capture_r);
      ADDR_EDGE_BUF:    rd_mux = zext(edge_width_buffer_r);
      ADDR_ENC_POS:     rd_mux = zext(encoder_position_counter);
      ADDR_ENC_SPD_CAP: rd_mux = zext(encoder_speed_capture_r);
      ADDR_ENC_POS_CAP: rd_mux = zext(encoder_position_capture_r);
      ADDR_CMD_CNT:     rd_mux = zext(command_pulse_counter);
      ADDR_CMD_SPD_CAP: rd_mux = zext(command_speed_capture_r);
      ADDR_CMD_POS_CAP: rd_mux = zext(command_position_capture_r);
      ADDR_SPD_DELTA:   rd_mux = zext(speed_delta_r);
      ADDR_STATUS:      rd_mux = status_word;
      ADDR_ANGLE:       rd_mux = {{(32-ANG_W){1'b0}}, hall_angle};
      default:          rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= 32'h0;
    else if (avs_read_i & ~ack_r)
      avs_readdata_o <= rd_mux;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      position_count_value_o <= '0;
      sensor_fault_o         <= 1'b0;
    end
    else
    begin
      position_count_value_o <= encoder_position_counter;
      sensor_fault_o         <= hall_fault;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  interval_count_a: assert property (!clr_match
      |=> interval_counter_r == $past(interval_counter_r) + CNT_W'(1))
    else $error("interval counter did not advance");
  interval_clear_a: assert property (clr_match |=> interval_counter_r == '0)
    else $error("interval counter not cleared on match");
  edge_capture_a: assert property (enc_edge
      |=> edge_width_capture_r == $past(interval_counter_r))
    else $error("edge width not captured");
  edge_buffer_a: assert property (enc_edge
      |=> edge_width_buffer_r == $past(edge_width_capture_r))
    else $error("edge width buffer not shifted");
  speed_capture_a: assert property (spd_match
      |=> encoder_speed_capture_r == $past(encoder_position_counter)
          && command_speed_capture_r == $past(command_pulse_counter))
    else $error("speed period capture missing");
  position_capture_a: assert property (pos_match
      |=> encoder_position_capture_r == $past(encoder_position_counter)
          && command_position_capture_r == $past(command_pulse_counter))
    else $error("position period capture missing");
  speed_delta_a: assert property (spd_match
      |=> speed_delta_r == $past(encoder_position_counter) - $past(encoder_speed_capture_r))
    else $error("speed delta wrong");
  index_zero_a: assert property (idx_rise
      |=> encoder_position_counter == '0 && index_seen_r)
    else $error("index did not zero position");
  cmd_count_a: assert property (cmd_edge
      |=> command_pulse_counter != $past(command_pulse_counter))
    else $error("command pulse not counted");
  bus_answer_a: assert property (req && !ack_r |=> !avs_waitrequest_o || !req)
    else $error("bus answer late");

endmodule : qec_capture

// File: rtl/qec_pkg.sv
// Purpose: Shared constants and types for the quadrature encoder capture block
// Assumes: 32-bit Avalon-MM register words at byte addresses, 100 MHz clk_i
// Notes:   Angles are electrical degrees, 0 to 359
package qec_pkg;

  localparam int          CNT_W_DEF        = 16;
  localparam int          ANG_W            = 9;

  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_SPD_CMP     = 8'h04;
  localparam logic [7:0]  ADDR_POS_CMP     = 8'h08;
  localparam logic [7:0]  ADDR_INTERVAL    = 8'h0c;
  localparam logic [7:0]  ADDR_EDGE_CAP    = 8'h10;
  localparam logic [7:0]  ADDR_EDGE_BUF    = 8'h14;
  localparam logic [7:0]  ADDR_ENC_POS     = 8'h18;
  localparam logic [7:0]  ADDR_ENC_SPD_CAP = 8'h1c;
  localparam logic [7:0]  ADDR_ENC_POS_CAP = 8'h20;
  localparam logic [7:0]  ADDR_CMD_CNT     = 8'h24;
  localparam logic [7:0]  ADDR_CMD_SPD_CAP = 8'h28;
  localparam logic [7:0]  ADDR_CMD_POS_CAP = 8'h2c;
  localparam logic [7:0]  ADDR_SPD_DELTA   = 8'h30;
  localparam logic [7:0]  ADDR_STATUS      = 8'h34;
  localparam logic [7:0]  ADDR_ANGLE       = 8'h38;

  localparam int          CTRL_CLR_SEL_BIT = 0;
  localparam logic        CTRL_CLR_SEL_RST = 1'b1;
  localparam logic [15:0] SPD_CMP_RST      = 16'h1387;
  localparam logic [15:0] POS_CMP_RST      = 16'h270f;

  localparam int          STAT_SECTOR_LSB  = 0;
  localparam int          STAT_FAULT_BIT   = 3;
  localparam int          STAT_TRACK_BIT   = 4;
  localparam int          STAT_INDEX_BIT   = 5;
  localparam int          STAT_ENC_DIR_BIT = 6;
  localparam int          STAT_CMD_DIR_BIT = 7;

  localparam logic [8:0]  SECTOR_DEG       = 9'h03c;
  localparam logic [8:0]  HALF_SECTOR_DEG  = 9'h01e;
  localparam logic [2:0]  SECTOR_NONE      = 3'h0;
  localparam logic [2:0]  SECTOR_FIRST     = 3'h1;
  localparam logic [2:0]  SECTOR_LAST      = 3'h6;

  typedef enum logic {
    HALL_WAIT  = 1'b0,
    HALL_TRACK = 1'b1
  } qec_hall_state_t;

endpackage : qec_pkg

// File: rtl/qec_quad.sv
// Purpose: Two-phase up/down counter, counting every edge of both phases
// Assumes: phase inputs asynchronous to clk_i
// Notes:   A step on both phases at once is dropped as invalid
module qec_quad
  import qec_pkg::*;
#(
  parameter int W = CNT_W_DEF
)
(
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         phase_a_i,
  input  wire logic         phase_b_i,
  input  wire logic         zero_i,
  output logic      [W-1:0] count_o,
  output logic              edge_o,
  output logic              dir_o
);

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  logic       up;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
      prev_r <= 2'h0;
    end
    else
    begin
      meta_r <= {phase_a_i, phase_b_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign edge_o = ^(sync_r ^ prev_r);
  assign up     = sync_r[1] ^ prev_r[0];

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      count_o <= '0;
      dir_o   <= 1'b0;
    end
    else if (zero_i)
      count_o <= '0;
    else if (edge_o)
    begin
      count_o <= up ? count_o + W'(1) : count_o - W'(1);
      dir_o   <= up;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  quad_up_step_a: assert property (edge_o && up && !zero_i
      |=> count_o == $past(count_o) + W'(1))
    else $error("count did not step up");
  quad_any_edge_a: assert property (edge_o && !zero_i |=> count_o != $past(count_o))
    else $error("phase edge not counted");

endmodule : qec_quad

// File: rtl/qec_hall.sv
// Purpose: Hall code to sector decode and coarse rotor angle
// Assumes: u, v, w inputs asynchronous to clk_i
// Notes:   Shows a fault for two cycles after reset while the synchroniser fills
module qec_hall
  import qec_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             hall_u_i,
  input  wire logic             hall_v_i,
  input  wire logic             hall_w_i,
  output logic      [2:0]       sector_o,
  output logic                  fault_o,
  output logic                  track_o,
  output logic      [ANG_W-1:0] angle_o
);

  logic [2:0]      meta_r;
  logic [2:0]      sync_r;
  logic [2:0]      cur_sec;
  qec_hall_state_t state_r;

  function automatic logic [2:0] sector_of(input logic [2:0] uvw);
    unique case (uvw)
      3'h5:    sector_of = 3'h1;
      3'h4:    sector_of = 3'h2;
      3'h6:    sector_of = 3'h3;
      3'h2:    sector_of = 3'h4;
      3'h3:    sector_of = 3'h5;
      3'h1:    sector_of = 3'h6;
      default: sector_of = SECTOR_NONE;
    endcase
  endfunction : sector_of

  function automatic logic [ANG_W-1:0] sec_base(input logic [2:0] s);
    sec_base = ANG_W'((ANG_W'(s) - ANG_W'(1)) * SECTOR_DEG);
  endfunction : sec_base

  function automatic logic [2:0] sec_next(input logic [2:0] s);
    sec_next = (s == SECTOR_LAST) ? SECTOR_FIRST : s + 3'h1;
  endfunction : sec_next

  function automatic logic [2:0] sec_prev(input logic [2:0] s);
    sec_prev = (s == SECTOR_FIRST) ? SECTOR_LAST : s - 3'h1;
  endfunction : sec_prev

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end
    else
    begin
      meta_r <= {hall_u_i, hall_v_i, hall_w_i};
      sync_r <= meta_r;
    end
  end

  assign cur_sec = sector_of(sync_r);
  assign track_o = (state_r == HALL_TRACK);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r  <= HALL_WAIT;
      sector_o <= SECTOR_NONE;
      fault_o  <= 1'b0;
      angle_o  <= '0;
    end
    else
    begin
      fault_o <= (cur_sec == SECTOR_NONE);
      if (cur_sec != SECTOR_NONE)
      begin
        sector_o <= cur_sec;
        unique case (state_r)
          HALL_WAIT:
          begin
            angle_o <= sec_base(cur_sec) + HALF_SECTOR_DEG;
            state_r <= HALL_TRACK;
          end
          HALL_TRACK:
          begin
            if (cur_sec == sec_next(sector_o))
              angle_o <= sec_base(cur_sec);
            else if (cur_sec == sec_prev(sector_o))
              angle_o <= sec_base(sector_o);
            else if (cur_sec != sector_o)
              angle_o <= sec_base(cur_sec) + HALF_SECTOR_DEG;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  hall_fault_hold_a: assert property (cur_sec == SECTOR_NONE
      |=> fault_o && $stable(angle_o))
    else $error("invalid hall code moved angle");
  hall_centre_a: assert property (!track_o && cur_sec != SECTOR_NONE
      |=> angle_o == sec_base($past(cur_sec)) + HALF_SECTOR_DEG && track_o)
    else $error("initial angle not sector centre");
  hall_forward_a: assert property (track_o && cur_sec != SECTOR_NONE
      && cur_sec == sec_next(sector_o) |=> angle_o == sec_base(sector_o))
    else $error("forward boundary angle wrong");

endmodule : qec_hall

// File: tb/qec_enc_model.sv
// Purpose: Encoder and Hall sensor model at the capture block pins
// Assumes: Steps spaced at least 5 clocks apart by the bench
// Notes:   Going up the phases run 00,10,11,01
module qec_enc_model
(
  input  wire logic       clk_i,
  input  wire logic       step_i,
  input  wire logic       up_i,
  input  wire logic       z_i,
  input  wire logic [2:0] hall_i,
  output logic            a_o,
  output logic            b_o,
  output logic            z_o,
  output logic            u_o,
  output logic            v_o,
  output logic            w_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r = 2'h0;
  // One phase moves per step, so A and B stay a quarter period apart
  always_ff @(posedge clk_i)
  begin
    if (step_i)
      ph_r <= up_i ? ph_r + 2'h1 : ph_r - 2'h1;
  end
  assign a_o = ph_r[1] ^ ph_r[0];
  assign b_o = ph_r[1];
  assign z_o = z_i;
  assign {u_o, v_o, w_o} = hall_i;
endmodule : qec_enc_model

// File: tb/quadrature_encoder_capture_tb.sv
// Purpose: Self-checking bench for the quadrature encoder capture block
// Assumes: Register map and latencies as handed over
// Notes:   Loop periods shortened by register writes
module quadrature_encoder_capture_tb import qec_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        step = 1'b0, up = 1'b1, z = 1'b0, ca = 1'b0, cb = 1'b0;
  logic [2:0]  hall = 3'h5;
  logic [7:0]  adr = 8'h0;
  logic        rd = 1'b0, wr = 1'b0, wreq, fault, a, b, zz, u, v, w;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [15:0] pos_o;
  logic [2:0]  hc [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  int          errors = 0, checks_done = 0, pos = 0, cst = 0, c1, n;

  initial forever #5 clk_i = ~clk_i;

  qec_enc_model i_enc (.clk_i(clk_i), .step_i(step), .up_i(up), .z_i(z), .hall_i(hall),
    .a_o(a), .b_o(b), .z_o(zz), .u_o(u), .v_o(v), .w_o(w));
  qec_capture i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .encoder_phase_a_in_i(a),
    .encoder_phase_b_in_i(b), .ext_clock_a_in_i(ca), .ext_clock_b_in_i(cb),
    .index_pulse_irq_in_i(zz), .hall_u_in_i(u), .hall_v_in_i(v), .hall_w_in_i(w),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .position_count_value_o(pos_o), .sensor_fault_o(fault));

  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w_, input logic [7:0] a_, input logic [31:0] d_);
    adr <= a_;
    wr <= w_;
    rd <= !w_;
    wd <= d_;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rdchk(input logic [7:0] a_, input logic [31:0] e);
    bus(1'b0, a_, 32'h0);
    chk(q, e);
  endtask : rdchk

  task automatic enc(input logic u_, input int k);
    repeat (k)
    begin
      step <= 1'b1;
      up <= u_;
      @(posedge clk_i);
      step <= 1'b0;
      pos += u_ ? 1 : -1;
      repeat (5) @(posedge clk_i);
    end
  endtask : enc

  task automatic cmd(input logic u_, input int k);
    repeat (k)
    begin
      cst += u_ ? 1 : -1;
      ca <= cst[1] ^ cst[0];
      cb <= cst[1];
      repeat (5) @(posedge clk_i);
    end
  endtask : cmd

  // Poll speed delta until it is neither the given value nor zero, up to 100 reads
  task automatic poll(input logic [31:0] old);
    for (int i = 0; i < 100 && (q === old || q === 32'h0); i++)
      bus(1'b0, ADDR_SPD_DELTA, 32'h0);
  endtask : poll

  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'hea3dbb23));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(ADDR_CTRL, 32'h1);
    rdchk(ADDR_SPD_CMP, 32'(SPD_CMP_RST));
    rdchk(ADDR_POS_CMP, 32'(POS_CMP_RST));
    rdchk(8'h3c, 32'h0);
    rdchk(ADDR_ANGLE, 32'h1e);
    bus(1'b1, ADDR_SPD_CMP, 32'h3f);
    bus(1'b1, ADDR_POS_CMP, 32'h7f);
    bus(1'b1, ADDR_ENC_POS, 32'h55);
    n = $urandom_range(12, 4);
    enc(1'b1, n);
    chk(32'(pos_o), 32'(pos[15:0]));
    enc(1'b0, n + 2);
    chk(32'(pos_o), 32'(pos[15:0]));
    cmd(1'b1, n + 3);
    cmd(1'b0, 1);
    rdchk(ADDR_CMD_CNT, 32'(cst[15:0]));
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(q[7:0]), 32'h11);
    bus(1'b0, ADDR_EDGE_CAP, 32'h0);
    chk(32'(q <= 32'h7f), 32'h1);
    c1 = q;
    enc(1'b1, 1);
    rdchk(ADDR_EDGE_BUF, c1);
    repeat (300) @(posedge clk_i);
    rdchk(ADDR_ENC_SPD_CAP, 32'(pos[15:0]));
    rdchk(ADDR_ENC_POS_CAP, 32'(pos[15:0]));
    rdchk(ADDR_CMD_SPD_CAP, 32'(cst[15:0]));
    rdchk(ADDR_CMD_POS_CAP, 32'(cst[15:0]));
    bus(1'b0, ADDR_INTERVAL, 32'h0);
    chk(32'(q <= 32'h7f), 32'h1);
    rdchk(ADDR_SPD_DELTA, 32'h0);
    enc(1'b1, 1);
    poll(32'h0);
    chk(q, 32'h1);
    enc(1'b0, 1);
    poll(32'h1);
    chk(q, 32'hffff);
    z <= 1'b1;
    pos = 0;
    repeat (4) @(posedge clk_i);
    z <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(pos_o), 32'(pos[15:0]));
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(q[STAT_INDEX_BIT]), 32'h1);
    // Speed compare raised to 7f before clearing moves to it, so no full wrap occurs
    bus(1'b1, ADDR_SPD_CMP, 32'h7f);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b1, ADDR_POS_CMP, 32'h3f);
    rdchk(ADDR_CTRL, 32'h0);
    c1 = 0;
    repeat (50)
    begin
      bus(1'b0, ADDR_INTERVAL, 32'h0);
      if (q > c1)
        c1 = q;
    end
    chk(32'(c1 > 32'h3f && c1 <= 32'h7f), 32'h1);
    for (int i = 1; i <= 6; i++)
    begin
      hall <= hc[i % 6];
      repeat (6) @(posedge clk_i);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(q[2:0]), 32'(i % 6 + 1));
      rdchk(ADDR_ANGLE, 32'(i % 6 * 'h3c));
    end
    hall <= 3'h1;
    repeat (6) @(posedge clk_i);
    hall <= 3'h3;
    repeat (6) @(posedge clk_i);
    rdchk(ADDR_ANGLE, 32'h12c);
    for (int i = 0; i < 2; i++)
    begin
      hall <= i ? 3'h0 : 3'h7;
      repeat (6) @(posedge clk_i);
      chk(32'(fault), 32'h1);
      rdchk(ADDR_ANGLE, 32'h12c);
    end
    hall <= 3'h5;
    repeat (6) @(posedge clk_i);
    chk(32'(fault), 32'h0);
    rdchk(ADDR_ANGLE, 32'h1e);
    report_and_stop();
  end
endmodule : quadrature_encoder_capture_tb
